//--- hw/htt_track_trigger.sv
// hodoscope track capture and delayed acquisition trigger
`timescale 1ns/100ps
// Notes on behaviour
// RULE1 - all 64 scintillator inputs are captured before the trigger is raised
// RULE2 - track word is latched before the host is told of a hit
// RULE3 - trigger only follows a detected hit, never anything else
// RULE4 - default delay from detection to trigger is 200 ns
// RULE5 - delay programmable from 100 ns to 300 ns in 10 ns steps
// RULE6 - acquisition side reads 216 samples on 12 channels within 1 ms
// RULE7 - acquisition side starts on the trigger for all 18 data sets
// RULE8 - path keeps up with about 10 events per second
// RULE9 - after storing a track the block needs reinitialising before next hit
// RULE10 - track word is 32 X channel bits then 32 Y channel bits
// RULE11 - 2-bit select picks one of four 16-bit slices for readout
// RULE12 - delay is a count of 10 ns steps loaded with 10 to 30
module htt_track_trigger
   import htt_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic [31:0] scint_x,
   input wire logic [31:0] scint_y,
   input wire logic hit_detect,
   input wire logic [htt_pkg::HTT_DLY_W-1:0] delay_steps,
   input wire logic host_reinit,
   input wire logic [htt_pkg::HTT_SEL_W-1:0] slice_sel,
   output logic acq_trigger,
   output logic event_ok,
   output logic [htt_pkg::HTT_SLICE_W-1:0] track_slice,
   output logic busy
);
   import htt_pkg::*;

   // ----------------------------------------
   // input synchronisers
   // ----------------------------------------
   // pins from the planes and the host module are asynchronous to clk
   logic [HTT_NCHAN-1:0] scint_s1_ff;
   logic [HTT_NCHAN-1:0] scint_s2_ff;
   logic [1:0] ctl_s1_ff;
   logic [1:0] ctl_s2_ff;
   logic [HTT_DLY_W-1:0] dly_s1_ff;
   logic [HTT_DLY_W-1:0] dly_s2_ff;
   logic [HTT_SEL_W-1:0] sel_s1_ff;
   logic [HTT_SEL_W-1:0] sel_s2_ff;
   logic hit_prev_ff;

   always_ff @(posedge clk) begin
      if (rst) begin
         scint_s1_ff <= HTT_TRACK_RST;
         scint_s2_ff <= HTT_TRACK_RST;
         ctl_s1_ff <= 2'h0;
         ctl_s2_ff <= 2'h0;
         dly_s1_ff <= HTT_DLY_RST;
         dly_s2_ff <= HTT_DLY_RST;
         sel_s1_ff <= 2'h0;
         sel_s2_ff <= 2'h0;
      end else if (ce) begin
         scint_s1_ff <= {scint_y, scint_x}; // RULE10
         scint_s2_ff <= scint_s1_ff;
         ctl_s1_ff <= {host_reinit, hit_detect};
         ctl_s2_ff <= ctl_s1_ff;
         dly_s1_ff <= delay_steps;
         dly_s2_ff <= dly_s1_ff;
         sel_s1_ff <= slice_sel;
         sel_s2_ff <= sel_s1_ff;
      end
   end

   logic hit_s;
   logic reinit_s;
   logic hit_rise;
   assign hit_s = ctl_s2_ff[0];
   assign reinit_s = ctl_s2_ff[1];
   assign hit_rise = hit_s && !hit_prev_ff;

   always_ff @(posedge clk) begin
      if (rst) begin
         hit_prev_ff <= 1'b0;
      end else if (ce) begin
         hit_prev_ff <= hit_s;
      end
   end

   // ----------------------------------------
   // delay setting
   // ----------------------------------------
   // out-of-range settings are clamped instead of ignored, so a bad host value
   // still yields a trigger inside the window
   logic [HTT_DLY_W-1:0] dly_clamped;
   always_comb begin
      if (dly_s2_ff < HTT_DLY_MIN_STEPS) begin
         dly_clamped = HTT_DLY_MIN_STEPS; // RULE5
      end else if (dly_s2_ff > HTT_DLY_MAX_STEPS) begin
         dly_clamped = HTT_DLY_MAX_STEPS; // RULE5
      end else begin
         dly_clamped = dly_s2_ff;
      end
   end

   // ----------------------------------------
   // event sequencer
   // ----------------------------------------
   htt_state_e state_ff;
   htt_state_e nxt_state;
   logic [HTT_NCHAN-1:0] track_ff;
   logic trig_ff;
   logic event_ok_ff;
   logic [HTT_SLICE_W-1:0] slice_ff;
   logic busy_ff;
   htt_dly_if dly ();

   htt_dly_timer u_timer (
      .clk(clk),
      .rst(rst),
      .ce(ce),
      .dly(dly)
   );

   assign dly.start = (state_ff == HTT_IDLE) && hit_rise; // RULE12
   assign dly.steps = dly_clamped;

   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         HTT_IDLE: begin
            if (hit_rise) begin
               nxt_state = HTT_WAIT;
            end
         end
         HTT_WAIT: begin
            if (dly.done) begin
               nxt_state = HTT_HELD;
            end
         end
         HTT_HELD: begin
            if (reinit_s) begin
               nxt_state = HTT_IDLE; // RULE9
            end
         end
         default: nxt_state = HTT_IDLE;
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         state_ff <= HTT_IDLE;
      end else if (ce) begin
         state_ff <= nxt_state;
      end
   end

   // track captured on the detection edge, well before the trigger fires
   always_ff @(posedge clk) begin
      if (rst) begin
         track_ff <= HTT_TRACK_RST;
      end else if (ce && state_ff == HTT_IDLE && hit_rise) begin
         track_ff <= scint_s2_ff; // RULE1 RULE2
      end
   end

   // one-cycle trigger only out of a waiting event
   always_ff @(posedge clk) begin
      if (rst) begin
         trig_ff <= 1'b0;
      end else if (ce) begin
         trig_ff <= (state_ff == HTT_WAIT) && dly.done; // RULE3 RULE4
      end
   end

   // host flag rises the cycle after the track is stored and holds to reinit
   always_ff @(posedge clk) begin
      if (rst) begin
         event_ok_ff <= 1'b0;
      end else if (ce) begin
         if (state_ff == HTT_WAIT) begin
            event_ok_ff <= 1'b1; // RULE2
         end else if (state_ff == HTT_HELD && reinit_s) begin
            event_ok_ff <= 1'b0; // RULE9
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         busy_ff <= 1'b0;
      end else if (ce) begin
         busy_ff <= (nxt_state != HTT_IDLE); // RULE8
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         slice_ff <= HTT_SLICE_RST;
      end else if (ce) begin
         slice_ff <= track_ff[sel_s2_ff*HTT_SLICE_W +: HTT_SLICE_W]; // RULE11
      end
   end

   assign acq_trigger = trig_ff; // RULE7
   assign event_ok = event_ok_ff;
   assign track_slice = slice_ff;
   assign busy = busy_ff;
endmodule

//--- hw/htt_pkg.sv
// constants and types shared by the track trigger block
package htt_pkg;
   // ----------------------------------------
   // geometry
   // ----------------------------------------
   localparam int unsigned HTT_NCHAN = 64;
   localparam int unsigned HTT_SLICE_W = 16;
   localparam int unsigned HTT_SEL_W = 2;
   localparam int unsigned HTT_X_LO = 0;
   localparam int unsigned HTT_Y_LO = 32;
   // ----------------------------------------
   // timing
   // ----------------------------------------
   localparam int unsigned HTT_CLK_PERIOD_NS = 25;
   localparam int unsigned HTT_STEP_NS = 10;
   localparam int unsigned HTT_DLY_MIN_NS = 100;
   localparam int unsigned HTT_DLY_MAX_NS = 300;
   localparam int unsigned HTT_DLY_DEF_NS = 200;
   localparam int unsigned HTT_DLY_W = 5;
   localparam logic [HTT_DLY_W-1:0] HTT_DLY_MIN_STEPS = 5'(HTT_DLY_MIN_NS / HTT_STEP_NS);
   localparam logic [HTT_DLY_W-1:0] HTT_DLY_MAX_STEPS = 5'(HTT_DLY_MAX_NS / HTT_STEP_NS);
   localparam logic [HTT_DLY_W-1:0] HTT_DLY_DEF_STEPS = 5'(HTT_DLY_DEF_NS / HTT_STEP_NS);
   // delay accumulator counts ns, not steps; this is its width in bits, and each cycle adds HTT_CLK_PERIOD_NS
   localparam int unsigned HTT_ACC_W = 10;
   localparam logic [HTT_ACC_W-1:0] HTT_ACC_RST = 10'h000;
   // trigger pulse width and reset values
   localparam int unsigned HTT_TRIG_CYC = 1;
   localparam logic [HTT_DLY_W-1:0] HTT_DLY_RST = HTT_DLY_DEF_STEPS;
   localparam logic [HTT_NCHAN-1:0] HTT_TRACK_RST = 64'h0000_0000_0000_0000;
   localparam logic [HTT_SLICE_W-1:0] HTT_SLICE_RST = 16'h0000;

   typedef enum logic [1:0] {
      HTT_IDLE = 2'b00,
      HTT_WAIT = 2'b01,
      HTT_HELD = 2'b10
   } htt_state_e;
endpackage

//--- hw/htt_dly_if.sv
// interface between the controller and its delay timer
`timescale 1ns/100ps
interface htt_dly_if;
   logic start;
   logic [htt_pkg::HTT_DLY_W-1:0] steps;
   logic done;
   modport ctl (output start, output steps, input done);
   modport tmr (input start, input steps, output done);
endinterface

//--- hw/htt_dly_timer.sv
// trigger delay timer adding 25 ns per clock toward a target of 10 ns steps in ns
`timescale 1ns/100ps
module htt_dly_timer
   import htt_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   htt_dly_if.tmr dly
);
   // ----------------------------------------
   // ns accumulator
   // ----------------------------------------
   // time in ns is accumulated rather than rounding each cycle to whole steps,
   // so the delay error stays below one clock period
   logic [HTT_ACC_W-1:0] elapsed_ff;
   logic [HTT_ACC_W-1:0] target_ff;
   logic running_ff;
   logic done_ff;

   always_ff @(posedge clk) begin
      if (rst) begin
         elapsed_ff <= HTT_ACC_RST;
         target_ff <= HTT_ACC_RST;
         running_ff <= 1'b0;
      end else if (ce) begin
         if (dly.start) begin
            elapsed_ff <= HTT_ACC_W'(HTT_CLK_PERIOD_NS);
            target_ff <= HTT_ACC_W'(dly.steps * HTT_STEP_NS); // RULE12
            running_ff <= 1'b1;
         end else if (running_ff) begin
            if (elapsed_ff >= target_ff) begin
               running_ff <= 1'b0;
            end else begin
               elapsed_ff <= elapsed_ff + HTT_ACC_W'(HTT_CLK_PERIOD_NS);
            end
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         done_ff <= 1'b0;
      end else if (ce) begin
         done_ff <= running_ff && !dly.start && (elapsed_ff >= target_ff);
      end
   end

   assign dly.done = done_ff;
endmodule

//--- verification/htt_track_trigger_asserts.sv
// checker for the track trigger ports
`timescale 1ns/100ps
module htt_chk (
   input wire logic clk,
   input wire logic rst,
   input wire logic hit_detect,
   input wire logic acq_trigger,
   input wire logic event_ok,
   input wire logic busy
);
   default clocking @(posedge clk);
   endclocking
   default disable iff (rst);
   trig_hit_a: assert property (acq_trigger |-> busy && event_ok)
      else $error("trigger outside event");
   cap_hit_a: assert property ($rose(busy) |-> $past(hit_detect))
      else $error("capture without hit");
   ok_after_a: assert property ($rose(busy) |=> event_ok)
      else $error("hit flag late");
   dly_win_a: assert property ($rose(busy) |-> ##[5:13] acq_trigger)
      else $error("trigger missing");
   early_trig_a: assert property ($rose(busy) |-> !acq_trigger [*5])
      else $error("trigger too early");
   trig_pulse_a: assert property (acq_trigger |=> !acq_trigger)
      else $error("trigger too long");
   ok_busy_a: assert property (event_ok |-> busy)
      else $error("flag without event");
   rst_clr_a: assert property ($fell(rst) |-> !busy && !event_ok)
      else $error("reset left state");
endmodule
bind htt_track_trigger htt_chk chk_u (
   .clk(clk),
   .rst(rst),
   .hit_detect(hit_detect),
   .acq_trigger(acq_trigger),
   .event_ok(event_ok),
   .busy(busy)
);

//--- verification/htt_host_model.sv
// acquisition and host side model
`timescale 1ns/100ps
module htt_host_model (
   input wire logic clk,
   input wire logic acq_trigger,
   input wire logic [15:0] track_slice,
   output logic [1:0] slice_sel,
   output logic host_reinit,
   output logic rd_stb,
   output logic [15:0] rd_data
);
   initial begin
      slice_sel = 2'h0;
      host_reinit = 1'b0;
      rd_stb = 1'b0;
      rd_data = 16'h0000;
      forever begin
         // trigger looked at mid-cycle, where it is settled
         @(negedge clk iff acq_trigger === 1'b1);
         for (int i = 0; i < 4; i++) begin
            @(negedge clk);
            slice_sel = 2'(i);
            // slice path has 3 cycles latency
            repeat (4) @(negedge clk);
            rd_data = track_slice;
            rd_stb = 1'b1;
            @(negedge clk);
            rd_stb = 1'b0;
         end
         host_reinit = 1'b1;
         repeat (3) @(negedge clk);
         host_reinit = 1'b0;
      end
   end
endmodule

//--- verification/tb_top.sv
// self-checking bench for the track trigger
`timescale 1ns/100ps
module tb_top;
   import htt_pkg::*;
   logic clk = 0, rst = 1, hit_detect = 0;
   logic [31:0] scint_x = 0, scint_y = 0;
   logic [4:0] delay_steps = HTT_DLY_DEF_STEPS;
   logic [1:0] slice_sel;
   logic host_reinit, acq_trigger, event_ok, busy, rd_stb;
   logic [15:0] track_slice, rd_data;
   logic [15:0] q[$];
   int err_count = 0, compares = 0;
   always #12.5 clk = ~clk;
   htt_track_trigger dut_u (.clk, .rst, .ce(1'b1), .scint_x, .scint_y,
      .hit_detect, .delay_steps, .host_reinit, .slice_sel, .acq_trigger,
      .event_ok, .track_slice, .busy);
   htt_host_model host_u (.clk, .acq_trigger, .track_slice, .slice_sel,
      .host_reinit, .rd_stb, .rd_data);
   task chk(input logic [15:0] g, input logic [15:0] e);
      compares++;
      if (g !== e) begin
         err_count++;
         $display("unexpected at %0t got %h exp %h", $time, g, e);
      end
   endtask
   task tally_and_finish;
      $display("compares %0d errors %0d", compares, err_count);
      if (err_count == 0 && compares > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   always @(posedge clk) begin
      if (rd_stb === 1'b1)
         chk(rd_data, q.pop_front());
   end
   task ev(input logic [31:0] x, input logic [31:0] y, input logic [4:0] s);
      int n, c, e;
      logic [63:0] w;
      c = (s < 10) ? 10 : (s > 30) ? 30 : s;
      // two sync edges, the capture edge, ceil(ns / 25) counts, then the trigger flop
      e = (c * 10 + 24) / 25 + 4;
      w = {y, x};
      for (int i = 0; i < 4; i++) q.push_back(w[16*i+:16]);
      @(negedge clk);
      scint_x = x;
      scint_y = y;
      delay_steps = s;
      hit_detect = 1;
      n = 0;
      while (acq_trigger !== 1'b1 && n < 60) begin
         @(negedge clk);
         n++;
      end
      chk(16'(n >= e - 1 && n <= e + 1), 16'h0001);
      chk({15'h0000, event_ok}, 16'h0001);
      // late pins and a second hit edge must not disturb the held word
      scint_x = ~x;
      scint_y = ~y;
      hit_detect = 0;
      repeat (3) @(negedge clk);
      hit_detect = 1;
      n = 0;
      while (busy !== 1'b0 && n < 300) begin
         @(negedge clk);
         n++;
      end
      chk({15'h0000, event_ok}, 16'h0000);
      hit_detect = 0;
      repeat (20) @(negedge clk);
      chk({15'h0000, busy}, 16'h0000);
   endtask
   initial begin
      void'($urandom(47112));
      repeat (2) @(negedge clk);
      rst = 0;
      ev(32'h8000_0001, 32'h0001_8000, HTT_DLY_DEF_STEPS);
      ev(32'hffff_0000, 32'h1234_5678, 5'h0a);
      ev(32'h0f0f_a5a5, 32'hc3c3_0ff0, 5'h1e);
      ev(32'h0000_ffff, 32'h5a5a_a5a5, 5'h05);
      ev(32'h7777_1111, 32'h8888_eeee, 5'h1f);
      for (int i = 0; i < 4; i++) ev($urandom, $urandom, 5'($urandom_range(30, 10)));
      tally_and_finish;
   end
   initial begin
      // far above nine events of under a hundred cycles each
      #750000;
      err_count++;
      tally_and_finish;
   end
endmodule
